// [bench/pcint_pin_model.sv]
// Driver model of the four external port pins
`timescale 1ns/1ns
module pcint_pin_model (
   input wire logic i_clk,
   input wire pcint_pkg::pcint_pins_type i_target,
   input wire logic i_slow,
   output pcint_pkg::pcint_pins_type o_pin
);
   import pcint_pkg::*;
   logic hold;
   initial begin
      o_pin = PCINT_PINS_RST;
      hold = 1'b0;
   end
   // Slow mode takes a change only every other cycle, like a lazy source
   always @(posedge i_clk) begin
      hold <= ~hold;
      if (!i_slow || hold) begin
         o_pin <= i_target;
      end
   end
endmodule

// [bench/tb.sv]
// Self-checking bench for the pin change interrupt block
`timescale 1ns/1ns
module tb;
   import pcint_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PCINT_AW-1:0] paddr = 8'h00;
   logic [PCINT_DW-1:0] pwdata = 32'h0;
   logic [PCINT_DW-1:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic wake;
   logic sleep = 1'b0;
   logic slow = 1'b0;
   pcint_pins_type target = 4'h0;
   pcint_pins_type pin;
   pcint_pins_type rise;
   pcint_pins_type fall;
   pcint_pins_type old;
   pcint_pins_type e;
   logic [31:0] seed = 32'hE421;
   logic [31:0] rd;
   logic er;
   logic fl [6];
   logic cl [6];
   int n;
   int dc;
   int ncol;
   int fail_count = 0;
   int checks_done = 0;

   always #50 i_clk = ~i_clk;

   pcint_top uut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_pin(pin), .i_sleep(sleep), .o_irq(irq),
      .o_wake(wake));
   pcint_pin_model model (.i_clk(i_clk), .i_target(target),
      .i_slow(slow), .o_pin(pin));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic pcint_pins_type exp_flags(input pcint_pins_type o,
         input pcint_pins_type v, input pcint_pins_type r,
         input pcint_pins_type f);
      return (v & ~o & r) | (~v & o & f);
   endfunction

   task automatic results;
      $display("Checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
   endtask

   // Setup, then access held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic r);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do begin
         @(posedge i_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      r = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         fail_count++;
         results;
      end
      @(posedge i_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, x);
   endtask

   initial begin
      repeat (16) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      rdc(PCINT_ADDR_RISE, 32'h0);
      rdc(PCINT_ADDR_FALL, 32'h0);
      rdc(PCINT_ADDR_FLAGS, 32'h0);
      rdc(PCINT_ADDR_CTRL, 32'h0);
      apb(1'b0, 8'h40, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      old = 4'h0;
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         rise = (i == 0) ? 4'hF : seed[3:0];
         fall = (i == 0) ? 4'hF : seed[7:4];
         wr(PCINT_ADDR_RISE, {seed[31:4], rise});
         wr(PCINT_ADDR_FALL, {seed[31:8], fall, seed[3:0]} >> 4);
         wr(PCINT_ADDR_FLAGS, 32'h0);
         rdc(PCINT_ADDR_RISE, {28'h0, rise});
         rdc(PCINT_ADDR_FALL, {28'h0, fall});
         slow <= seed[12];
         target <= (i == 0) ? 4'hF : seed[11:8];
         cyc(8);
         e = exp_flags(old, (i == 0) ? 4'hF : seed[11:8], rise, fall);
         old = (i == 0) ? 4'hF : seed[11:8];
         rdc(PCINT_ADDR_FLAGS, {28'h0, e});
         rdc(PCINT_ADDR_CTRL, {31'h0, |e});
         chk({31'h0, wake}, 32'h0);
      end
      wr(PCINT_ADDR_RISE, 32'hF);
      target <= ~old;
      cyc(8);
      wr(PCINT_ADDR_RISE, 32'h0);
      wr(PCINT_ADDR_FALL, 32'h0);
      target <= old;
      cyc(8);
      e = e | exp_flags(old, ~old, 4'hF, fall);
      rdc(PCINT_ADDR_FLAGS, {28'h0, e});
      wr(PCINT_ADDR_FLAGS, 32'h0);
      rdc(PCINT_ADDR_FLAGS, 32'h0);
      // Interrupt and wake, edge seen while asleep
      slow <= 1'b0;
      target <= 4'h0;
      wr(PCINT_ADDR_CTRL, 32'h8);
      wr(PCINT_ADDR_IEN, 32'h1);
      wr(PCINT_ADDR_RISE, 32'hF);
      wr(PCINT_ADDR_FLAGS, 32'h0);
      wr(PCINT_ADDR_ICLR, 32'h3);
      sleep <= 1'b1;
      target <= 4'h5;
      n = 0;
      while (wake !== 1'b1 && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 20) begin
         fail_count++;
         results;
      end
      chk({31'h0, wake}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      sleep <= 1'b0;
      rdc(PCINT_ADDR_FLAGS, 32'h5);
      rdc(PCINT_ADDR_ISTAT, 32'h1);
      wr(PCINT_ADDR_IEN, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(PCINT_ADDR_IEN, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(PCINT_ADDR_ICLR, 32'h1);
      rdc(PCINT_ADDR_ISTAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(PCINT_ADDR_CTRL, 32'h0);
      chk({31'h0, wake}, 32'h0);
      rdc(PCINT_ADDR_CTRL, 32'h1);
      // Sweep a clearing write across one pin edge
      wr(PCINT_ADDR_FALL, 32'hF);
      for (int d = 0; d < 6; d++) begin
         wr(PCINT_ADDR_FLAGS, 32'h0);
         wr(PCINT_ADDR_ICLR, 32'h3);
         target <= target ^ 4'h1;
         cyc(d);
         wr(PCINT_ADDR_FLAGS, 32'h0);
         cyc(6);
         apb(1'b0, PCINT_ADDR_FLAGS, 32'h0, rd, er);
         fl[d] = rd[0];
         apb(1'b0, PCINT_ADDR_ISTAT, 32'h0, rd, er);
         cl[d] = rd[PCINT_EVT_COLLIDE];
      end
      ncol = 0;
      dc = -1;
      for (int d = 0; d < 6; d++) begin
         if (cl[d] === 1'b1) begin
            ncol++;
            dc = d;
         end
      end
      chk(ncol, 32'h1);
      for (int d = 0; d < 6; d++) begin
         chk({31'h0, fl[d]}, (d <= dc) ? 32'h1 : 32'h0);
      end
      // Reset in mid-run clears everything again
      wr(PCINT_ADDR_RISE, 32'hF);
      i_srst <= 1'b1;
      cyc(2);
      i_srst <= 1'b0;
      @(posedge i_clk);
      rdc(PCINT_ADDR_RISE, 32'h0);
      rdc(PCINT_ADDR_FALL, 32'h0);
      rdc(PCINT_ADDR_FLAGS, 32'h0);
      // High pins across a reset must not look like edges
      i_srst <= 1'b1;
      cyc(2);
      i_srst <= 1'b0;
      wr(PCINT_ADDR_RISE, 32'hF);
      cyc(4);
      rdc(PCINT_ADDR_FLAGS, 32'h0);
      results;
   end
endmodule

// [design/pcint_edge.sv]
// Pin synchronisers and qualified edge detectors
`timescale 1ns/1ns
module pcint_edge (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire pcint_pkg::pcint_pins_type i_pin,
   input wire pcint_pkg::pcint_pins_type i_rise_en,
   input wire pcint_pkg::pcint_pins_type i_fall_en,
   output pcint_pkg::pcint_pins_type o_rise_hit,
   output pcint_pkg::pcint_pins_type o_fall_hit
);
   import pcint_pkg::*;

   pcint_pins_type sync_a;
   pcint_pins_type sync_b;
   pcint_pins_type prev;
   logic [2:0] arm;

   // Hold off until prev holds a real sample, else a high pin fakes an edge
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         arm <= PCINT_ARM_RST;
      end else begin
         arm <= {arm[1:0], 1'b1};
      end
   end

   genvar g;
   generate
      for (g = 0; g < PCINT_NPINS; g++) begin : g_pin
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               sync_a[g] <= 1'b0;
               sync_b[g] <= 1'b0;
               prev[g] <= 1'b0;
            end else begin
               sync_a[g] <= i_pin[g];
               sync_b[g] <= sync_a[g];
               prev[g] <= sync_b[g];
            end
         end
         assign o_rise_hit[g] = arm[2] & i_rise_en[g] & sync_b[g] & ~prev[g];
         assign o_fall_hit[g] = arm[2] & i_fall_en[g] & ~sync_b[g] & prev[g];
      end
   endgenerate
endmodule

// [design/pcint_irq.sv]
// Sticky event status with enable and write-one-to-clear
`timescale 1ns/1ns
module pcint_irq (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire pcint_pkg::pcint_evt_type i_event,
   input wire logic i_clr_wr,
   input wire logic i_en_wr,
   input wire pcint_pkg::pcint_evt_type i_wdata,
   output pcint_pkg::pcint_evt_type o_status,
   output pcint_pkg::pcint_evt_type o_enable,
   output logic o_irq
);
   import pcint_pkg::*;

   pcint_evt_type clr_mask;

   assign clr_mask = i_clr_wr ? i_wdata : PCINT_EVT_RST;

   // Set beats clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_status <= PCINT_EVT_RST;
      end else begin
         o_status <= (o_status & ~clr_mask) | i_event;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_enable <= PCINT_EVT_RST;
      end else if (i_en_wr) begin
         o_enable <= i_wdata;
      end
   end

   assign o_irq = |(o_status & o_enable);
endmodule

// [design/pcint_top.sv]
// Pin change detector with APB registers, interrupt and wake
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns

// What this block does
// - With the master enable set, a flagged edge raises wake, and raises the interrupt when enable bit 0 is also set.
// - An edge seen in Sleep is in the flag register before wake is signalled.
// - Rising enable bits 3..0 turn on rising-edge detection per pin.
// - Falling enable bits 3..0 turn on falling-edge detection per pin.
// - A pin flag sets on an enabled rising or enabled falling edge.
// - A pin flag is set by hardware or by writing one to it, and stays set until written to zero.
// - Writing zero to a pin flag clears it.
// - Bits 7..4 of the enable and flag registers always read as zero.
// - An interrupt from a change also needs the master enable bit.
// - Enables and flags reset to zero on every reset.
// - Detection and flag setting go on with the master enable clear.
// - The aggregate flag is the OR of the four pin flags.
// - An edge during a clearing write leaves its flag set.
module pcint_top (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [pcint_pkg::PCINT_AW-1:0] i_paddr,
   input wire logic [pcint_pkg::PCINT_DW-1:0] i_pwdata,
   output logic [pcint_pkg::PCINT_DW-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire pcint_pkg::pcint_pins_type i_pin,
   input wire logic i_sleep,
   output logic o_irq,
   output logic o_wake
);
   import pcint_pkg::*;

   function automatic logic pcint_hit(
      input logic [PCINT_AW-1:0] addr,
      input logic [PCINT_AW-1:0] target
   );
      pcint_hit = (addr == target);
   endfunction

   function automatic logic pcint_mapped(input logic [PCINT_AW-1:0] addr);
      pcint_mapped = pcint_hit(addr, PCINT_ADDR_RISE)
         | pcint_hit(addr, PCINT_ADDR_FALL)
         | pcint_hit(addr, PCINT_ADDR_FLAGS)
         | pcint_hit(addr, PCINT_ADDR_CTRL)
         | pcint_hit(addr, PCINT_ADDR_ISTAT)
         | pcint_hit(addr, PCINT_ADDR_ICLR)
         | pcint_hit(addr, PCINT_ADDR_IEN);
   endfunction

   pcint_pins_type rise_en;
   pcint_pins_type fall_en;
   pcint_pins_type flags;
   pcint_pins_type next_flags;
   pcint_pins_type rise_hit;
   pcint_pins_type fall_hit;
   pcint_pins_type hits;
   pcint_pins_type wr_pins;
   pcint_evt_type events;
   pcint_evt_type irq_status;
   pcint_evt_type irq_enable;
   logic master_en;
   logic agg_flag;
   logic setup;
   logic access_wr;
   logic wr_rise;
   logic wr_fall;
   logic wr_flags;
   logic wr_ctrl;
   logic wr_iclr;
   logic wr_ien;
   logic [PCINT_DW-1:0] next_rdata;

   // Bus phases
   assign setup = i_psel & ~i_penable;
   assign o_pready = i_psel & i_penable;
   assign access_wr = o_pready & i_pwrite;
   assign wr_rise = access_wr & pcint_hit(i_paddr, PCINT_ADDR_RISE);
   assign wr_fall = access_wr & pcint_hit(i_paddr, PCINT_ADDR_FALL);
   assign wr_flags = access_wr & pcint_hit(i_paddr, PCINT_ADDR_FLAGS);
   assign wr_ctrl = access_wr & pcint_hit(i_paddr, PCINT_ADDR_CTRL);
   assign wr_iclr = access_wr & pcint_hit(i_paddr, PCINT_ADDR_ICLR);
   assign wr_ien = access_wr & pcint_hit(i_paddr, PCINT_ADDR_IEN);
   assign wr_pins = i_pwdata[PCINT_NPINS-1:0];

   pcint_edge u_edge (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_pin(i_pin),
      .i_rise_en(rise_en),
      .i_fall_en(fall_en),
      .o_rise_hit(rise_hit),
      .o_fall_hit(fall_hit)
   );

   assign hits = rise_hit | fall_hit;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rise_en <= PCINT_PINS_RST;
      end else if (wr_rise) begin
         rise_en <= wr_pins;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         fall_en <= PCINT_PINS_RST;
      end else if (wr_fall) begin
         fall_en <= wr_pins;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         master_en <= 1'b0;
      end else if (wr_ctrl) begin
         master_en <= i_pwdata[PCINT_CTRL_MEN_BIT];
      end
   end

   always_comb begin
      next_flags = flags | hits;
      if (wr_flags) begin
         next_flags = wr_pins | hits;
      end
   end

   // sticky, master enable not consulted, reset
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         flags <= PCINT_PINS_RST;
      end else begin
         flags <= next_flags;
      end
   end

   assign agg_flag = |flags;

   assign events[PCINT_EVT_CHANGE] = master_en & (|hits);
   // edge that a clearing write would have lost
   assign events[PCINT_EVT_COLLIDE] = wr_flags & (|(hits & ~wr_pins));

   pcint_irq u_irq (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_event(events),
      .i_clr_wr(wr_iclr),
      .i_en_wr(wr_ien),
      .i_wdata(i_pwdata[PCINT_NEVT-1:0]),
      .o_status(irq_status),
      .o_enable(irq_enable),
      .o_irq(o_irq)
   );

   // wake follows flags, flag already stored when it rises
   assign o_wake = master_en & agg_flag;

   always_comb begin
      next_rdata = PCINT_DATA_ZERO;
      if (pcint_hit(i_paddr, PCINT_ADDR_RISE)) begin
         next_rdata[PCINT_NPINS-1:0] = rise_en;
      end
      if (pcint_hit(i_paddr, PCINT_ADDR_FALL)) begin
         next_rdata[PCINT_NPINS-1:0] = fall_en;
      end
      if (pcint_hit(i_paddr, PCINT_ADDR_FLAGS)) begin
         next_rdata[PCINT_NPINS-1:0] = flags;
      end
      if (pcint_hit(i_paddr, PCINT_ADDR_CTRL)) begin
         next_rdata[PCINT_CTRL_MEN_BIT] = master_en;
         next_rdata[PCINT_CTRL_AGG_BIT] = agg_flag;
      end
      if (pcint_hit(i_paddr, PCINT_ADDR_ISTAT)) begin
         next_rdata[PCINT_NEVT-1:0] = irq_status;
      end
      if (pcint_hit(i_paddr, PCINT_ADDR_IEN)) begin
         next_rdata[PCINT_NEVT-1:0] = irq_enable;
      end
   end

   // Read data captured in setup so it comes from a flop
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_prdata <= PCINT_DATA_ZERO;
      end else if (setup) begin
         o_prdata <= i_pwrite ? PCINT_DATA_ZERO : next_rdata;
      end
   end

   // Unmapped address answers with an error, no stall
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_pslverr <= 1'b0;
      end else if (setup) begin
         o_pslverr <= ~pcint_mapped(i_paddr);
      end
   end

   property p_edge_sets_flag;
      @(posedge i_clk) disable iff (i_srst)
      (|hits) |=> ((flags & $past(hits)) == $past(hits));
   endproperty
   a_edge_sets_flag: assert property (p_edge_sets_flag)
      else $error("enabled edge did not set its flag");

   property p_flag_sticky;
      @(posedge i_clk) disable iff (i_srst)
      !wr_flags |=> ((flags & $past(flags)) == $past(flags));
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("pin flag dropped without a write");

   property p_flag_clear;
      @(posedge i_clk) disable iff (i_srst)
      (wr_flags && hits == PCINT_PINS_RST) |=> (flags == $past(wr_pins));
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag write not stored");

   property p_clear_collide;
      @(posedge i_clk) disable iff (i_srst)
      wr_flags |=> ((flags & $past(hits)) == $past(hits));
   endproperty
   a_clear_collide: assert property (p_clear_collide)
      else $error("edge lost during flag clear");

   property p_upper_zero;
      @(posedge i_clk) disable iff (i_srst)
      (setup && !i_pwrite && (pcint_hit(i_paddr, PCINT_ADDR_RISE)
         || pcint_hit(i_paddr, PCINT_ADDR_FALL)
         || pcint_hit(i_paddr, PCINT_ADDR_FLAGS)))
      |=> (o_prdata[PCINT_DW-1:PCINT_NPINS] == '0);
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("unimplemented bits read nonzero");

   property p_agg_read;
      @(posedge i_clk) disable iff (i_srst)
      (setup && !i_pwrite && pcint_hit(i_paddr, PCINT_ADDR_CTRL))
      |=> (o_prdata[PCINT_CTRL_AGG_BIT] == $past(|flags));
   endproperty
   a_agg_read: assert property (p_agg_read)
      else $error("aggregate flag differs from OR of flags");

   property p_detect_no_master;
      @(posedge i_clk) disable iff (i_srst)
      (!master_en && |hits) |=> (|flags);
   endproperty
   a_detect_no_master: assert property (p_detect_no_master)
      else $error("detection stopped with master enable clear");

   property p_wake;
      @(posedge i_clk) disable iff (i_srst)
      o_wake == (master_en && (|flags));
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake does not follow flags and master enable");

   property p_change_needs_master;
      @(posedge i_clk) disable iff (i_srst)
      $rose(irq_status[PCINT_EVT_CHANGE]) |-> $past(master_en);
   endproperty
   a_change_needs_master: assert property (p_change_needs_master)
      else $error("change status set without master enable");

   property p_sleep_flag_first;
      @(posedge i_clk) disable iff (i_srst)
      (i_sleep && $rose(o_wake)) |-> ($past(|hits) && (|flags));
   endproperty
   a_sleep_flag_first: assert property (p_sleep_flag_first)
      else $error("wake raised before flag stored");

   property p_reset_zero;
      @(posedge i_clk) disable iff (i_srst)
      $past(i_srst) |-> (flags == PCINT_PINS_RST
         && rise_en == PCINT_PINS_RST && fall_en == PCINT_PINS_RST);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("enables or flags not zero after reset");

   property p_rise_write;
      @(posedge i_clk) disable iff (i_srst)
      wr_rise |=> (rise_en == $past(wr_pins))
         ##1 (rise_en == $past(wr_pins, 2));
   endproperty
   a_rise_write: assert property (p_rise_write)
      else $error("rising enable not held after write");

   property p_fall_write;
      @(posedge i_clk) disable iff (i_srst)
      (wr_fall && !$past(wr_fall)) |=> (fall_en == $past(wr_pins));
   endproperty
   a_fall_write: assert property (p_fall_write)
      else $error("falling enable not stored");

   property p_no_enable_no_flag;
      @(posedge i_clk) disable iff (i_srst)
      (rise_en == PCINT_PINS_RST && fall_en == PCINT_PINS_RST)
      |-> (hits == PCINT_PINS_RST);
   endproperty
   a_no_enable_no_flag: assert property (p_no_enable_no_flag)
      else $error("edge reported with all enables clear");
endmodule

// [include/pcint_pkg.sv]
// Shared constants for the pin change interrupt block
package pcint_pkg;
   localparam int unsigned PCINT_NPINS = 4;
   localparam int unsigned PCINT_AW = 8;
   localparam int unsigned PCINT_DW = 32;
   localparam int unsigned PCINT_NEVT = 2;

   // Register byte addresses
   localparam logic [PCINT_AW-1:0] PCINT_ADDR_RISE = 8'h00;
   localparam logic [PCINT_AW-1:0] PCINT_ADDR_FALL = 8'h04;
   localparam logic [PCINT_AW-1:0] PCINT_ADDR_FLAGS = 8'h08;
   localparam logic [PCINT_AW-1:0] PCINT_ADDR_CTRL = 8'h0C;
   localparam logic [PCINT_AW-1:0] PCINT_ADDR_ISTAT = 8'h10;
   localparam logic [PCINT_AW-1:0] PCINT_ADDR_ICLR = 8'h14;
   localparam logic [PCINT_AW-1:0] PCINT_ADDR_IEN = 8'h18;

   // Field positions in interrupt_control
   localparam int unsigned PCINT_CTRL_MEN_BIT = 3;
   localparam int unsigned PCINT_CTRL_AGG_BIT = 0;

   // Event positions in the status, clear and enable registers
   localparam int unsigned PCINT_EVT_CHANGE = 0;
   localparam int unsigned PCINT_EVT_COLLIDE = 1;

   // Reset values
   localparam logic [PCINT_NPINS-1:0] PCINT_PINS_RST = 4'h0;
   localparam logic [PCINT_NEVT-1:0] PCINT_EVT_RST = 2'h0;
   localparam logic [PCINT_DW-1:0] PCINT_DATA_ZERO = 32'h0000_0000;
   localparam logic [2:0] PCINT_ARM_RST = 3'h0;

   typedef logic [PCINT_NPINS-1:0] pcint_pins_type;
   typedef logic [PCINT_NEVT-1:0] pcint_evt_type;
endpackage
